// ==== hw/pcrs_pkg.sv ====
// Purpose: constants and types of the program counter and return stack
// Assumes: APB register window, 32-bit data, byte data in the low bits
// Notes: one register per aligned word, upper data bits read as zero
//
// Contract
// - counter is 21 bits held as low, high and upper bytes
// - low byte is software read/write; high byte only through high latch
// - upper byte holds bits 20..16, reached only through upper latch
// - writing the low byte loads high and upper bytes from the latches
// - reading the low byte copies high and upper bytes into the latches
// - counter bit 0 is always zero; sequential step is two
// - calls, jumps and branches load the counter, ignoring the latches
// - calls and interrupt acknowledge push the counter; 31 nested levels
// - returns pop the counter; calls and returns leave latches alone
// - stack is 31 entries of 21 bits, 5-bit pointer, own address space
// - push increments pointer first, then writes the selected entry
// - pop loads counter from selected entry, then decrements pointer
// - every reset clears pointer; pointer zero has no storage behind it
// - only the selected entry is visible, as three read/write bytes
// - software reads and writes the pointer, range 0 to 31
// - 32nd push sets overflow flag; cleared by software or power-on
// - with option on, overflow also resets and forces pointer to zero
// - with option off, pointer stays 31 and pushes overwrite entry 31
// - software setting the overflow flag causes no reset
// - pop returning zero sets underflow flag; software or power-on clear
// - with option on, empty pop loads zero, sets flag and resets
// - with option off, empty pop loads zero and sets flag only
package pcrs_pkg;
    localparam int PC_W = 21;
    localparam int PTR_W = 5;
    localparam int UP_W = 5;
    localparam int ADDR_W = 8;
    localparam int DEPTH = 31;
    localparam logic [PTR_W-1:0] PTR_MAX = 5'h1F;
    localparam logic [PTR_W-1:0] PTR_ONE = 5'h01;
    localparam logic [PTR_W-1:0] PTR_RST = 5'h00;
    localparam logic [PC_W-1:0] PC_STEP = 21'h000002;
    localparam logic [PC_W-1:0] PC_RST = 21'h000000;
    // register byte offsets
    localparam logic [ADDR_W-1:0] OFF_PC_LOW = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_HIGH_LATCH = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_UPPER_LATCH = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_TOP_LOW = 8'h0C;
    localparam logic [ADDR_W-1:0] OFF_TOP_HIGH = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_TOP_UPPER = 8'h14;
    localparam logic [ADDR_W-1:0] OFF_STACK_PTR = 8'h18;
    localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h1C;
    localparam logic [ADDR_W-1:0] OFF_CONFIG = 8'h20;
    // field positions and reset values
    localparam int STAT_OVF_BIT = 0;
    localparam int STAT_UNF_BIT = 1;
    localparam int CFG_OPT_BIT = 0;
    localparam logic CFG_OPT_RST = 1'b1;
    // core requests
    typedef enum logic [2:0] {
        OP_IDLE,
        OP_STEP,
        OP_JUMP,
        OP_CALL,
        OP_RETURN
    } pcrs_op_t;
endpackage

// ==== hw/pcrs_top.sv ====
// Purpose: program counter, byte latches and 31-level return stack
// Assumes: core requests one operation per enabled cycle
// Notes: software access completes one cycle after the access phase
`timescale 1ns/1ps
`default_nettype none
module pcrs_top (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic por_b,
    input wire logic ce,
    input wire pcrs_pkg::pcrs_op_t core_op,
    input wire logic [pcrs_pkg::PC_W-1:0] core_target,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [pcrs_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [pcrs_pkg::PC_W-1:0] pc,
    output logic stack_overflow_flag,
    output logic stack_underflow_flag,
    output logic stack_reset_req
);
    import pcrs_pkg::*;

    logic [PC_W-1:0] pc_reg, pc_next;
    logic [7:0] high_byte_latch_reg, high_byte_latch_next;
    logic [UP_W-1:0] upper_byte_latch_reg, upper_byte_latch_next;
    logic [PTR_W-1:0] ptr_reg, ptr_next;
    logic ovf_reg, ovf_next, unf_reg, unf_next;
    logic opt_reg, opt_next;
    logic req_reg, req_next;
    logic pready_reg, pslverr_reg;
    logic [31:0] prdata_reg;
    logic [PC_W-1:0] stack_reg [1:DEPTH];
    logic wr_en;
    logic [PTR_W-1:0] wr_idx;
    logic [PC_W-1:0] wr_val;
    logic ovf_set, unf_set;
    logic [7:0] rd_byte;
    logic hit;

    // access phase first cycle; the answer follows one cycle later
    wire acc = psel & penable & ~pready_reg;
    wire sw_wr = acc & pwrite;
    wire sw_rd = acc & ~pwrite;
    wire a_low = paddr == OFF_PC_LOW;
    wire a_lath = paddr == OFF_HIGH_LATCH;
    wire a_latu = paddr == OFF_UPPER_LATCH;
    wire a_top_lo = paddr == OFF_TOP_LOW;
    wire a_top_hi = paddr == OFF_TOP_HIGH;
    wire a_top_up = paddr == OFF_TOP_UPPER;
    wire a_ptr = paddr == OFF_STACK_PTR;
    wire a_stat = paddr == OFF_STATUS;
    wire a_cfg = paddr == OFF_CONFIG;
    wire [7:0] wbyte = pwdata[7:0];

    // stack state seen by core and software
    wire empty = ptr_reg == PTR_RST;
    wire full = ptr_reg == PTR_MAX;
    wire [PC_W-1:0] top_entry = empty ? PC_RST : stack_reg[ptr_reg];
    wire [PTR_W-1:0] ptr_inc = ptr_reg + PTR_ONE;
    wire [PTR_W-1:0] ptr_dec = ptr_reg - PTR_ONE;
    wire push_op = ce & (core_op == OP_CALL);
    wire pop_op = ce & (core_op == OP_RETURN);
    wire top_wr = sw_wr & (a_top_lo | a_top_hi | a_top_up);

    // software byte merged into the top entry
    wire [PC_W-1:0] top_merge = a_top_lo ?
        {top_entry[PC_W-1:8], wbyte} : a_top_hi ?
        {top_entry[PC_W-1:16], wbyte, top_entry[7:0]} :
        {wbyte[UP_W-1:0], top_entry[15:0]};

    // read decode
    always_comb begin
        hit = 1'b1;
        rd_byte = 8'h00;
        if (a_low) begin
            rd_byte = pc_reg[7:0];
        end else if (a_lath) begin
            rd_byte = high_byte_latch_reg;
        end else if (a_latu) begin
            rd_byte = 8'(upper_byte_latch_reg);
        end else if (a_top_lo) begin
            rd_byte = top_entry[7:0];
        end else if (a_top_hi) begin
            rd_byte = top_entry[15:8];
        end else if (a_top_up) begin
            rd_byte = 8'(top_entry[PC_W-1:16]);
        end else if (a_ptr) begin
            rd_byte = 8'(ptr_reg);
        end else if (a_stat) begin
            rd_byte = 8'({unf_reg, ovf_reg});
        end else if (a_cfg) begin
            rd_byte = 8'(opt_reg);
        end else begin
            hit = 1'b0;
        end
    end

    // core operations, then software writes on top
    always_comb begin
        pc_next = pc_reg;
        ptr_next = ptr_reg;
        high_byte_latch_next = high_byte_latch_reg;
        upper_byte_latch_next = upper_byte_latch_reg;
        opt_next = opt_reg;
        ovf_set = 1'b0;
        unf_set = 1'b0;
        req_next = 1'b0;
        wr_en = 1'b0;
        wr_idx = ptr_reg;
        wr_val = pc_reg;
        if (ce) begin
            case (core_op)
                OP_STEP: begin
                    pc_next = pc_reg + PC_STEP;
                end
                OP_JUMP: begin
                    pc_next = {core_target[PC_W-1:1], 1'b0};
                end
                OP_CALL: begin
                    pc_next = {core_target[PC_W-1:1], 1'b0};
                    if (full) begin
                        ovf_set = 1'b1;
                        if (opt_reg) begin
                            ptr_next = PTR_RST;
                            req_next = 1'b1;
                        end else begin
                            wr_en = 1'b1;
                        end
                    end else begin
                        ptr_next = ptr_inc;
                        wr_idx = ptr_inc;
                        wr_en = 1'b1;
                    end
                end
                OP_RETURN: begin
                    if (empty) begin
                        pc_next = PC_RST;
                        unf_set = 1'b1;
                        req_next = opt_reg;
                    end else begin
                        pc_next = {top_entry[PC_W-1:1], 1'b0};
                        ptr_next = ptr_dec;
                    end
                end
                default: begin
                end
            endcase
        end
        if (sw_wr && a_low) begin
            pc_next = {upper_byte_latch_reg, high_byte_latch_reg,
                wbyte[7:1], 1'b0};
        end
        if (sw_rd && a_low) begin
            high_byte_latch_next = pc_reg[15:8];
            upper_byte_latch_next = pc_reg[PC_W-1:16];
        end
        if (sw_wr && a_lath) begin
            high_byte_latch_next = wbyte;
        end
        if (sw_wr && a_latu) begin
            upper_byte_latch_next = wbyte[UP_W-1:0];
        end
        if (sw_wr && a_ptr) begin
            ptr_next = wbyte[PTR_W-1:0];
        end
        if (sw_wr && a_cfg) begin
            opt_next = wbyte[CFG_OPT_BIT];
        end
        if (top_wr && !wr_en && !empty) begin
            wr_en = 1'b1;
            wr_val = top_merge;
        end
    end

    // flags: hardware set wins over a software clear
    wire sw_stat = sw_wr & a_stat;
    assign ovf_next = (sw_stat ? wbyte[STAT_OVF_BIT] : ovf_reg) | ovf_set;
    assign unf_next = (sw_stat ? wbyte[STAT_UNF_BIT] : unf_reg) | unf_set;

    // storage entries 1..31; pointer zero has none
    for (genvar i = 1; i <= DEPTH; i++) begin : g_ent
        wire we = wr_en & (wr_idx == PTR_W'(i));
        always_ff @(posedge clk) begin
            if (!rst_b) begin
                stack_reg[i] <= PC_RST;
            end else if (ce && we) begin
                stack_reg[i] <= wr_val;
            end
        end
    end

    // counter, latches and pointer
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            pc_reg <= PC_RST;
            high_byte_latch_reg <= 8'h00;
            upper_byte_latch_reg <= '0;
            ptr_reg <= PTR_RST;
            opt_reg <= CFG_OPT_RST;
            req_reg <= 1'b0;
        end else if (ce) begin
            pc_reg <= pc_next;
            high_byte_latch_reg <= high_byte_latch_next;
            upper_byte_latch_reg <= upper_byte_latch_next;
            ptr_reg <= ptr_next;
            opt_reg <= opt_next;
            req_reg <= req_next;
        end
    end

    // flags survive all but power-on reset
    always_ff @(posedge clk) begin
        if (!por_b) begin
            ovf_reg <= 1'b0;
            unf_reg <= 1'b0;
        end else if (ce) begin
            ovf_reg <= ovf_next;
            unf_reg <= unf_next;
        end
    end

    // bus answer
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h00000000;
        end else if (ce) begin
            pready_reg <= acc;
            pslverr_reg <= acc & ~hit;
            prdata_reg <= sw_rd ? 32'(rd_byte) : prdata_reg;
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign pc = pc_reg;
    assign stack_overflow_flag = ovf_reg;
    assign stack_underflow_flag = unf_reg;
    assign stack_reset_req = req_reg;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b || !por_b);

    // helper terms for the checks
    wire quiet = !acc;
    wire idle_core = ce & (core_op == OP_IDLE);

    // stack events free of any bus access
    sequence s_push_room;
        push_op && !full && quiet;
    endsequence
    sequence s_push_full;
        push_op && full && quiet;
    endsequence
    sequence s_pop_empty;
        pop_op && empty && quiet;
    endsequence

    // reset request stands one cycle; a pop on the empty stack may renew it
    sequence s_req_once;
        req_reg ##1 (!req_reg || $past(pop_op));
    endsequence

    // bus answer stands one cycle unless the clock enable froze it
    sequence s_answer;
        pready_reg ##1 (!pready_reg || !$past(ce));
    endsequence

    // counter alignment and sequential step
    a_pc_even: assert property (pc_reg[0] == 1'b0)
        else $error("counter bit 0 set");
    a_step_two: assert property
        (ce && core_op == OP_STEP && quiet |=>
        pc_reg == $past(pc_reg + PC_STEP))
        else $error("step did not add two");

    // push and pop of the return stack
    a_push_store: assert property (s_push_room |=>
        ptr_reg == $past(ptr_inc) && top_entry == $past(pc_reg))
        else $error("push did not store");
    a_pop_load: assert property (pop_op && !empty && quiet |=>
        pc_reg == $past({top_entry[PC_W-1:1], 1'b0}) &&
        ptr_reg == $past(ptr_dec))
        else $error("pop did not load");
    a_stack_latch: assert property
        ((push_op || pop_op) && quiet |=>
        $stable(high_byte_latch_reg) && $stable(upper_byte_latch_reg))
        else $error("stack operation moved a latch");

    // overflow with and without the reset option
    a_ovf_reset: assert property ((s_push_full and opt_reg) |=>
        (ovf_reg && ptr_reg == PTR_RST) ##0 s_req_once)
        else $error("overflow reset wrong");
    a_ovf_hold: assert property ((s_push_full and !opt_reg) |=>
        ovf_reg && ptr_reg == PTR_MAX && !req_reg &&
        stack_reg[PTR_MAX] == $past(pc_reg))
        else $error("overflow hold wrong");
    a_ovf_sticky: assert property (ovf_reg && !(sw_wr && a_stat)
        |=> ovf_reg)
        else $error("overflow flag lost");
    a_stat_write: assert property (sw_wr && a_stat && idle_core |=>
        !req_reg && ovf_reg == $past(wbyte[STAT_OVF_BIT]))
        else $error("status write misbehaved");

    // underflow with and without the reset option
    a_unf_zero: assert property (s_pop_empty |=>
        unf_reg && pc_reg == PC_RST && req_reg == $past(opt_reg))
        else $error("underflow wrong");
    a_unf_sticky: assert property (unf_reg && !(sw_wr && a_stat)
        |=> unf_reg)
        else $error("underflow flag lost");
    a_unf_reset: assert property ((s_pop_empty and opt_reg) |=>
        pc_reg == PC_RST ##0 s_req_once)
        else $error("underflow reset wrong");
    a_unf_quiet: assert property ((s_pop_empty and !opt_reg) |=>
        pc_reg == PC_RST && ptr_reg == PTR_RST && !req_reg)
        else $error("underflow without option wrong");

    // counter low byte and the two latches
    a_low_write: assert property (sw_wr && a_low && ce |=>
        pc_reg[PC_W-1:8] == $past({upper_byte_latch_reg,
        high_byte_latch_reg}))
        else $error("low write did not load latches");
    a_low_read: assert property (sw_rd && a_low && ce |=>
        {upper_byte_latch_reg, high_byte_latch_reg} ==
        $past(pc_reg[PC_W-1:8]) && pready_reg)
        else $error("low read did not copy bytes");
    a_latch_high: assert property (sw_wr && a_lath && ce |=>
        high_byte_latch_reg == $past(wbyte))
        else $error("high latch write lost");
    a_latch_upper: assert property (sw_wr && a_latu && ce |=>
        upper_byte_latch_reg == $past(wbyte[UP_W-1:0]))
        else $error("upper latch write lost");
    a_jump_direct: assert property
        (ce && core_op == OP_JUMP && quiet |=>
        pc_reg == $past({core_target[PC_W-1:1], 1'b0}) &&
        $stable(high_byte_latch_reg))
        else $error("jump load wrong");

    // pointer, option and top entry seen by software
    a_reset_ptr: assert property (!$past(rst_b) |->
        ptr_reg == PTR_RST && pc_reg == PC_RST)
        else $error("reset left pointer or counter");
    a_ptr_write: assert property (sw_wr && a_ptr && ce |=>
        ptr_reg == $past(wbyte[PTR_W-1:0]))
        else $error("pointer write lost");
    a_opt_write: assert property (sw_wr && a_cfg && ce |=>
        opt_reg == $past(wbyte[CFG_OPT_BIT]))
        else $error("option write lost");
    a_top_write: assert property
        (top_wr && a_top_lo && ce && !empty && !push_op && !pop_op |=>
        top_entry[7:0] == $past(wbyte))
        else $error("top entry write lost");

    // bus answer, read data and clock enable
    a_bus_answer: assert property (acc && ce |=>
        (s_answer and (pslverr_reg == $past(!hit))))
        else $error("bus answer wrong");
    a_rdata_hold: assert property (!(sw_rd && ce) |=>
        $stable(prdata_reg))
        else $error("read data changed without a read");
    a_ce_freeze: assert property (!ce |=>
        $stable(pc_reg) && $stable(ptr_reg) && $stable(ovf_reg) &&
        $stable(pready_reg))
        else $error("state moved with clock enable low");
endmodule
`default_nettype wire

// ==== verif/pcrs_core_model.sv ====
// Purpose: core-side model issuing counter and stack requests
// Assumes: the bench asks one cycle ahead through go, op_in, tgt_in
// Notes: target is scrambled while idle, as a released bus would be
`timescale 1ns/1ps
`default_nettype none
module pcrs_core_model (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic go,
    input wire pcrs_pkg::pcrs_op_t op_in,
    input wire logic [pcrs_pkg::PC_W-1:0] tgt_in,
    output pcrs_pkg::pcrs_op_t core_op,
    output logic [pcrs_pkg::PC_W-1:0] core_target
);
    import pcrs_pkg::*;
    // one-cycle request, idle and inverted target otherwise
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            core_op <= OP_IDLE;
            core_target <= '0;
        end else begin
            core_op <= go ? op_in : OP_IDLE;
            core_target <= go ? tgt_in : ~core_target;
        end
    end
endmodule
`default_nettype wire

// ==== verif/program_counter_return_stack_tb.sv ====
// Purpose: self-checking bench for counter, latches and return stack
// Assumes: ce held high except during its freeze test
// Notes: read results are queued and checked by a monitor process
`timescale 1ns/1ps
`default_nettype none
module program_counter_return_stack_tb;
    import pcrs_pkg::*;
    logic clk = 0, rst_b = 0, por_b = 0, ce = 1, go = 0;
    pcrs_op_t op_in = OP_IDLE, core_op;
    logic [PC_W-1:0] tgt_in = '0, core_target, pc, e, t;
    logic psel = 0, penable = 0, pwrite = 0, pready, pslverr, ovf, unf, rreq;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, seed = 32'h1F;
    logic [7:0] exp_q[$];
    int mismatches = 0, total_checks = 0, rreq_cnt = 0, cycles = 0;
    // free-running clock
    always #5 clk = ~clk;
    pcrs_core_model i_pcrs_core_model (.clk(clk), .rst_b(rst_b), .go(go),
        .op_in(op_in), .tgt_in(tgt_in), .core_op(core_op),
        .core_target(core_target));
    pcrs_top i_pcrs_top (.clk(clk), .rst_b(rst_b), .por_b(por_b), .ce(ce),
        .core_op(core_op), .core_target(core_target), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .pc(pc),
        .stack_overflow_flag(ovf), .stack_underflow_flag(unf),
        .stack_reset_req(rreq));
    task check(input logic [31:0] seen, input logic [31:0] want);
        total_checks++;
        if (seen !== want) begin
            mismatches++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, want);
        end
    endtask
    function logic [31:0] xs(input logic [31:0] s);
        logic [31:0] r;
        r = s ^ (s << 13);
        r = r ^ (r >> 17);
        xs = r ^ (r << 5);
    endfunction
    task rnd();
        seed = xs(seed);
        t = seed[PC_W-1:0];
    endtask
    task finish_test();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // one transfer: setup, access held until pready
    task apb(input logic w, input logic [7:0] a, input logic [7:0] d,
             input logic err);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        penable <= 1'b0;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n == 20) mismatches++;
        check(pslverr, err);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, d, 1'b0);
    endtask
    task rd(input logic [7:0] a, input logic [7:0] x);
        exp_q.push_back(x);
        apb(1'b0, a, 8'h00, 1'b0);
    endtask
    // request through the core model, then let the result land
    task core(input pcrs_op_t o, input logic [PC_W-1:0] tg);
        @(posedge clk);
        go <= 1'b1;
        op_in <= o;
        tgt_in <= tg;
        @(posedge clk);
        go <= 1'b0;
        repeat (2) @(posedge clk);
    endtask
    // read-data monitor, reset-request counter and timeout
    always @(posedge clk) begin
        if (pready === 1'b1 && psel === 1'b1 && pwrite === 1'b0) begin
            if (exp_q.size() == 0) mismatches++;
            else check(prdata, {24'h0, exp_q.pop_front()});
        end
        if (rreq === 1'b1) rreq_cnt++;
        cycles++;
        if (cycles == 4000) begin
            mismatches++;
            finish_test();
        end
    end
    // main sequence
    initial begin
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        por_b <= 1'b1;
        rd(OFF_CONFIG, 8'h01);
        rd(OFF_STACK_PTR, 8'h00);
        rd(OFF_PC_LOW, 8'h00);
        rd(OFF_STATUS, 8'h00);
        $display("test reset done");
        rnd();
        e = t & 21'h1FFFFE;
        core(OP_JUMP, t);
        check(pc, e);
        rd(OFF_PC_LOW, e[7:0]);
        rd(OFF_HIGH_LATCH, e[15:8]);
        rd(OFF_UPPER_LATCH, {3'h0, e[20:16]});
        wr(OFF_HIGH_LATCH, 8'h12);
        wr(OFF_UPPER_LATCH, 8'h03);
        wr(OFF_PC_LOW, 8'h57);
        check(pc, 21'h031256);
        core(OP_STEP, '0);
        check(pc, 21'h031258);
        $display("test counter done");
        ce <= 1'b0;
        core(OP_STEP, '0);
        check(pc, 21'h031258);
        ce <= 1'b1;
        rnd();
        core(OP_CALL, t);
        check(pc, t & 21'h1FFFFE);
        rd(OFF_STACK_PTR, 8'h01);
        rd(OFF_TOP_LOW, 8'h58);
        rd(OFF_TOP_HIGH, 8'h12);
        rd(OFF_TOP_UPPER, 8'h03);
        rd(OFF_HIGH_LATCH, 8'h12);
        wr(OFF_TOP_LOW, 8'h5D);
        rd(OFF_TOP_LOW, 8'h5D);
        core(OP_RETURN, '0);
        check(pc, 21'h03125C);
        rd(OFF_STACK_PTR, 8'h00);
        apb(1'b1, 8'h24, 8'h5A, 1'b1);
        $display("test call done");
        wr(OFF_CONFIG, 8'h00);
        wr(OFF_STACK_PTR, 8'h1E);
        rnd();
        e = t & 21'h1FFFFE;
        core(OP_CALL, t);
        rnd();
        core(OP_CALL, t);
        rd(OFF_STACK_PTR, 8'h1F);
        rd(OFF_TOP_LOW, e[7:0]);
        rd(OFF_STATUS, 8'h01);
        wr(OFF_STATUS, 8'h00);
        rd(OFF_STATUS, 8'h00);
        wr(OFF_STATUS, 8'h01);
        check(rreq_cnt, 0);
        wr(OFF_CONFIG, 8'h01);
        wr(OFF_STACK_PTR, 8'h1F);
        wr(OFF_STATUS, 8'h00);
        core(OP_CALL, t);
        rd(OFF_STACK_PTR, 8'h00);
        rd(OFF_STATUS, 8'h01);
        check(rreq_cnt, 1);
        check(ovf, 1'b1);
        $display("test overflow done");
        core(OP_RETURN, '0);
        check(pc, 21'h000000);
        rd(OFF_STATUS, 8'h03);
        check(rreq_cnt, 2);
        check(unf, 1'b1);
        wr(OFF_CONFIG, 8'h00);
        wr(OFF_STATUS, 8'h00);
        core(OP_JUMP, 21'h000100);
        core(OP_RETURN, '0);
        check(pc, 21'h000000);
        rd(OFF_STATUS, 8'h02);
        check(rreq_cnt, 2);
        $display("test underflow done");
        wr(OFF_STACK_PTR, 8'h05);
        @(posedge clk);
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        rd(OFF_STACK_PTR, 8'h00);
        rd(OFF_STATUS, 8'h02);
        @(posedge clk);
        rst_b <= 1'b0;
        por_b <= 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        por_b <= 1'b1;
        rd(OFF_STATUS, 8'h00);
        check({unf, ovf}, 2'b00);
        $display("test resets done");
        finish_test();
    end
endmodule
`default_nettype wire
